// ### src/flash_op_defines.svh
`ifndef FLASH_OP_DEFINES_SVH
`define FLASH_OP_DEFINES_SVH

// Operation status word bit positions.
`define BIT_CHECK_RESULT 0
`define BIT_LOCKED_ERR 1
`define BIT_PROG_SUSP 2
`define BIT_BUF_ABORT 3
`define BIT_PROG_FAIL 4
`define BIT_ERASE_FAIL 5
`define BIT_ERASE_SUSP 6
`define BIT_READY 7
// Result bits 5, 4, 3, 1 and 0 as a mask over bits 8:0.
`define RESULT_MASK 9'h03B
// Bits 8:0 after reset; bit 7 is built from the controller state.
`define STAT_RESET_LOW 9'h000

// Timing.
`define CLK_PERIOD_NS 10
`define PROT_BUSY_NS 20000
`define PROT_BUSY_CYCLES (`PROT_BUSY_NS / `CLK_PERIOD_NS)
`define OP_CYCLES 16'h0010

// Host register offsets on APB.
`define HOST_CMD_OFS 12'h000
`define HOST_READ_OFS 12'h004
`define HOST_WORD_OFS 12'h008
`define HOST_STAT_OFS 12'h00C

`endif

// ### src/flash_op_pkg.sv
package flash_op_pkg;

  typedef enum logic [3:0] {
    CMD_NOP = 4'h0,
    CMD_STATUS_READ = 4'h1,
    CMD_CLEAR_STATUS = 4'h2,
    CMD_SW_RESET = 4'h3,
    CMD_PROGRAM = 4'h4,
    CMD_ERASE = 4'h5,
    CMD_BLANK_CHECK = 4'h6,
    CMD_PW_UNLOCK = 4'h7,
    CMD_BUF_WRITE = 4'h8,
    CMD_WB_ABORT_RESET = 4'h9,
    CMD_ERASE_SUSPEND = 4'hA,
    CMD_ERASE_RESUME = 4'hB,
    CMD_PROG_SUSPEND = 4'hC,
    CMD_PROG_RESUME = 4'hD,
    CMD_ERASE_QUERY = 4'hE
  } cmd_t;

  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_BUSY = 5'h02,
    S_PROT = 5'h04,
    S_EOP_ERR = 5'h08,
    S_ABORT = 5'h10
  } dev_state_t;

  typedef enum logic [1:0] {
    H_IDLE = 2'h1,
    H_READ = 2'h2
  } host_state_t;

endpackage

// ### src/flash_op_status_dev.sv
`timescale 1ns/1ps
`include "flash_op_defines.svh"

module flash_op_status_dev (
  input wire logic pclk,
  input wire logic presetn,
  op_link_if.dev link,
  input wire logic target_protected,
  input wire logic op_fail,
  input wire logic wbuf_error,
  input wire logic [15:0] array_word,
  output logic [15:0] status_word,
  output logic device_ready_flag
);
  flash_op_pkg::dev_state_t state_reg, state_next;
  flash_op_pkg::cmd_t op_reg, op_next;
  logic [8:0] stat_reg, stat_next;
  logic [15:0] cnt_reg, cnt_next;
  logic [15:0] saved_reg, saved_next;
  logic [3:0] susp_sector_reg, susp_sector_next;
  logic overlay_reg, overlay_next;
  logic [15:0] snap_reg;
  logic [3:0] burst_left_reg;
  logic burst_first_reg;
  logic burst_ovl_reg;
  logic rd_strobe_reg;
  logic [15:0] rd_data_reg;
  logic rd_done_reg;
  logic [6:0] noise_reg;
  logic erase_ok_mem [16];

  wire logic burst_active = (burst_left_reg != 4'h0);
  wire logic cmd_take = link.cmd_valid && !burst_active;
  wire flash_op_pkg::cmd_t cmd = link.cmd_code;
  wire logic running = (state_reg == flash_op_pkg::S_BUSY) ||
                       (state_reg == flash_op_pkg::S_PROT);
  wire logic ready_bit = !running;
  wire logic is_clear = (cmd == flash_op_pkg::CMD_CLEAR_STATUS) ||
                        (cmd == flash_op_pkg::CMD_SW_RESET);
  wire logic erase_blocked = stat_reg[`BIT_ERASE_SUSP] || stat_reg[`BIT_PROG_SUSP];
  wire logic prog_blocked = stat_reg[`BIT_PROG_SUSP] ||
    (stat_reg[`BIT_ERASE_SUSP] && link.cmd_sector == susp_sector_reg);
  wire logic op_done = (cnt_reg == 16'h0001);
  wire logic erase_finish = (state_reg == flash_op_pkg::S_BUSY) && op_done &&
                            (op_reg == flash_op_pkg::CMD_ERASE);
  // Reserved bits follow a free counter, so they genuinely vary between reads.
  wire logic [15:0] junk_word = {noise_reg, noise_reg, noise_reg[1:0]};
  wire logic [15:0] live_word = {noise_reg, stat_reg[8], ready_bit, stat_reg[6:0]};

  assign status_word = live_word;
  assign device_ready_flag = ready_bit;
  assign link.rd_strobe = rd_strobe_reg;
  assign link.rd_data = rd_data_reg;
  assign link.rd_done = rd_done_reg;
  assign link.burst_busy = burst_active;

  always_comb begin
    state_next = state_reg;
    op_next = op_reg;
    stat_next = stat_reg;
    cnt_next = cnt_reg;
    saved_next = saved_reg;
    susp_sector_next = susp_sector_reg;
    overlay_next = overlay_reg;
    if (link.rd_req && !burst_active) begin
      overlay_next = 1'b0;
    end
    if (cmd_take && cmd == flash_op_pkg::CMD_STATUS_READ) begin
      overlay_next = 1'b1;
    end
    case (state_reg)
      flash_op_pkg::S_IDLE: begin
        if (cmd_take) begin
          case (cmd)
            flash_op_pkg::CMD_CLEAR_STATUS, flash_op_pkg::CMD_SW_RESET: begin
              stat_next = stat_reg & ~`RESULT_MASK;
            end
            flash_op_pkg::CMD_PROGRAM: begin
              stat_next[`BIT_LOCKED_ERR] = 1'b0;
              stat_next[`BIT_PROG_FAIL] = 1'b0;
              op_next = cmd;
              if (prog_blocked) begin
                stat_next[`BIT_PROG_FAIL] = 1'b1;
                state_next = flash_op_pkg::S_EOP_ERR;
              end else if (target_protected) begin
                cnt_next = 16'(`PROT_BUSY_CYCLES);
                state_next = flash_op_pkg::S_PROT;
              end else begin
                cnt_next = `OP_CYCLES;
                state_next = flash_op_pkg::S_BUSY;
              end
            end
            flash_op_pkg::CMD_ERASE: begin
              stat_next[`BIT_LOCKED_ERR] = 1'b0;
              op_next = cmd;
              if (erase_blocked) begin
                stat_next[`BIT_ERASE_FAIL] = 1'b1;
                state_next = flash_op_pkg::S_EOP_ERR;
              end else begin
                stat_next[`BIT_ERASE_FAIL] = 1'b0;
                stat_next[`BIT_ERASE_SUSP] = 1'b0;
                susp_sector_next = link.cmd_sector;
                if (target_protected) begin
                  cnt_next = 16'(`PROT_BUSY_CYCLES);
                  state_next = flash_op_pkg::S_PROT;
                end else begin
                  cnt_next = `OP_CYCLES;
                  state_next = flash_op_pkg::S_BUSY;
                end
              end
            end
            flash_op_pkg::CMD_BLANK_CHECK, flash_op_pkg::CMD_PW_UNLOCK,
            flash_op_pkg::CMD_BUF_WRITE: begin
              op_next = cmd;
              cnt_next = `OP_CYCLES;
              state_next = flash_op_pkg::S_BUSY;
            end
            flash_op_pkg::CMD_ERASE_RESUME: begin
              if (stat_reg[`BIT_ERASE_SUSP] && !stat_reg[`BIT_PROG_SUSP]) begin
                stat_next[`BIT_ERASE_SUSP] = 1'b0;
                op_next = flash_op_pkg::CMD_ERASE;
                cnt_next = saved_reg;
                state_next = flash_op_pkg::S_BUSY;
              end
            end
            flash_op_pkg::CMD_PROG_RESUME: begin
              if (stat_reg[`BIT_PROG_SUSP]) begin
                stat_next[`BIT_PROG_SUSP] = 1'b0;
                op_next = flash_op_pkg::CMD_PROGRAM;
                cnt_next = saved_reg;
                state_next = flash_op_pkg::S_BUSY;
              end
            end
            flash_op_pkg::CMD_ERASE_QUERY: begin
              stat_next[`BIT_CHECK_RESULT] = erase_ok_mem[link.cmd_sector];
            end
            default: begin
            end
          endcase
        end
      end
      flash_op_pkg::S_BUSY: begin
        if (cmd_take && cmd == flash_op_pkg::CMD_ERASE_SUSPEND &&
            op_reg == flash_op_pkg::CMD_ERASE) begin
          saved_next = cnt_reg;
          stat_next[`BIT_ERASE_SUSP] = 1'b1;
          state_next = flash_op_pkg::S_IDLE;
        end else if (cmd_take && cmd == flash_op_pkg::CMD_PROG_SUSPEND &&
                     op_reg == flash_op_pkg::CMD_PROGRAM && !stat_reg[`BIT_ERASE_SUSP]) begin
          saved_next = cnt_reg;
          stat_next[`BIT_PROG_SUSP] = 1'b1;
          state_next = flash_op_pkg::S_IDLE;
        end else if (op_done) begin
          state_next = flash_op_pkg::S_IDLE;
          case (op_reg)
            flash_op_pkg::CMD_PROGRAM, flash_op_pkg::CMD_PW_UNLOCK: begin
              if (op_fail) begin
                stat_next[`BIT_PROG_FAIL] = 1'b1;
                state_next = flash_op_pkg::S_EOP_ERR;
              end
            end
            flash_op_pkg::CMD_ERASE, flash_op_pkg::CMD_BLANK_CHECK: begin
              if (op_fail) begin
                stat_next[`BIT_ERASE_FAIL] = 1'b1;
                state_next = flash_op_pkg::S_EOP_ERR;
              end
            end
            flash_op_pkg::CMD_BUF_WRITE: begin
              if (wbuf_error) begin
                stat_next[`BIT_BUF_ABORT] = 1'b1;
                stat_next[`BIT_PROG_FAIL] = 1'b1;
                stat_next[`BIT_ERASE_FAIL] = 1'b0;
                stat_next[`BIT_PROG_SUSP] = 1'b0;
                stat_next[`BIT_LOCKED_ERR] = 1'b0;
                state_next = flash_op_pkg::S_ABORT;
              end
            end
            default: begin
            end
          endcase
          if (state_next == flash_op_pkg::S_EOP_ERR) begin
            stat_next[`BIT_PROG_SUSP] = 1'b0;
            stat_next[`BIT_LOCKED_ERR] = 1'b0;
          end
        end else begin
          cnt_next = cnt_reg - 16'h0001;
        end
      end
      // Only status read gets through here; it is handled above.
      flash_op_pkg::S_PROT: begin
        if (op_done) begin
          stat_next[`BIT_LOCKED_ERR] = 1'b1;
          stat_next[`BIT_PROG_SUSP] = 1'b0;
          if (op_reg == flash_op_pkg::CMD_ERASE) begin
            stat_next[`BIT_ERASE_FAIL] = 1'b1;
          end else begin
            stat_next[`BIT_PROG_FAIL] = 1'b1;
          end
          state_next = flash_op_pkg::S_IDLE;
        end else begin
          cnt_next = cnt_reg - 16'h0001;
        end
      end
      flash_op_pkg::S_EOP_ERR: begin
        if (cmd_take && is_clear) begin
          stat_next = stat_reg & ~`RESULT_MASK;
          state_next = flash_op_pkg::S_IDLE;
        end
      end
      flash_op_pkg::S_ABORT: begin
        if (cmd_take && (cmd == flash_op_pkg::CMD_CLEAR_STATUS ||
                         cmd == flash_op_pkg::CMD_WB_ABORT_RESET)) begin
          stat_next = stat_reg & ~`RESULT_MASK;
          state_next = flash_op_pkg::S_IDLE;
        end
      end
      default: begin
        state_next = flash_op_pkg::S_IDLE;
      end
    endcase
    // Anything not matched above leaves state and status alone.
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= flash_op_pkg::S_IDLE;
      op_reg <= flash_op_pkg::CMD_NOP;
      stat_reg <= `STAT_RESET_LOW;
      cnt_reg <= 16'h0000;
      saved_reg <= 16'h0000;
      susp_sector_reg <= 4'h0;
      overlay_reg <= 1'b0;
      noise_reg <= 7'h00;
    end else begin
      state_reg <= state_next;
      op_reg <= op_next;
      stat_reg <= stat_next;
      cnt_reg <= cnt_next;
      saved_reg <= saved_next;
      susp_sector_reg <= susp_sector_next;
      overlay_reg <= overlay_next;
      noise_reg <= noise_reg + 7'h25;
    end
  end

  // The snapshot is taken when the status read command arrives, not at the read.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      snap_reg <= 16'h0080;
    end else if (cmd_take && cmd == flash_op_pkg::CMD_STATUS_READ) begin
      snap_reg <= live_word;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 16; i++) begin
        erase_ok_mem[i] <= 1'b0;
      end
    end else if (erase_finish) begin
      erase_ok_mem[susp_sector_reg] <= !op_fail;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      burst_left_reg <= 4'h0;
      burst_first_reg <= 1'b0;
      burst_ovl_reg <= 1'b0;
      rd_strobe_reg <= 1'b0;
      rd_data_reg <= 16'h0000;
      rd_done_reg <= 1'b0;
    end else begin
      rd_done_reg <= 1'b0;
      if (!burst_active && link.rd_req) begin
        burst_left_reg <= (link.rd_len == 4'h0) ? 4'h1 : link.rd_len;
        burst_first_reg <= 1'b1;
        burst_ovl_reg <= overlay_reg;
      end else if (burst_active) begin
        rd_strobe_reg <= !rd_strobe_reg;
        if (burst_first_reg && burst_ovl_reg) begin
          rd_data_reg <= snap_reg;
        end else if (burst_ovl_reg || running) begin
          rd_data_reg <= junk_word;
        end else begin
          rd_data_reg <= array_word;
        end
        burst_first_reg <= 1'b0;
        burst_left_reg <= burst_left_reg - 4'h1;
        rd_done_reg <= (burst_left_reg == 4'h1);
      end
    end
  end
endmodule

// ### src/flash_op_status_host.sv
`timescale 1ns/1ps
`include "flash_op_defines.svh"

module flash_op_status_host (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  op_link_if.host link
);
  flash_op_pkg::host_state_t state_reg;
  logic cmd_valid_reg;
  flash_op_pkg::cmd_t cmd_code_reg;
  logic [3:0] cmd_sector_reg;
  logic rd_req_reg;
  logic [3:0] rd_len_reg;
  logic status_armed_reg;
  logic status_burst_reg;
  logic first_seen_reg;
  logic [15:0] word_reg;
  logic [15:0] valid_status_reg;
  logic status_valid_reg;
  logic suspend_pending_reg;

  wire logic access = psel && penable;
  wire logic wr_cmd = access && pwrite && paddr == `HOST_CMD_OFS;
  wire logic wr_read = access && pwrite && paddr == `HOST_READ_OFS;
  wire logic known = paddr == `HOST_CMD_OFS || paddr == `HOST_READ_OFS ||
                     paddr == `HOST_WORD_OFS || paddr == `HOST_STAT_OFS;
  wire logic host_busy = (state_reg != flash_op_pkg::H_IDLE) || cmd_valid_reg ||
                         rd_req_reg || link.burst_busy;
  wire flash_op_pkg::cmd_t new_cmd = flash_op_pkg::cmd_t'(pwdata[3:0]);
  // Reserved upper bits are cleared only when the read directly follows the status read command.
  wire logic [15:0] masked_word = {7'h00, link.rd_data[8:0]};
  wire logic status_ready = link.rd_data[`BIT_READY];

  assign pready = 1'b1;
  assign pslverr = access && !known;
  assign prdata = (paddr == `HOST_WORD_OFS) ? {16'h0000, word_reg} :
                  (paddr == `HOST_STAT_OFS) ?
                  {valid_status_reg, 13'h0000, suspend_pending_reg, status_valid_reg,
                   host_busy} : 32'h0000_0000;
  assign link.cmd_valid = cmd_valid_reg;
  assign link.cmd_code = cmd_code_reg;
  assign link.cmd_sector = cmd_sector_reg;
  assign link.rd_req = rd_req_reg;
  assign link.rd_len = rd_len_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= flash_op_pkg::H_IDLE;
      cmd_valid_reg <= 1'b0;
      cmd_code_reg <= flash_op_pkg::CMD_NOP;
      cmd_sector_reg <= 4'h0;
      rd_req_reg <= 1'b0;
      rd_len_reg <= 4'h0;
      status_armed_reg <= 1'b0;
      status_burst_reg <= 1'b0;
      first_seen_reg <= 1'b0;
      suspend_pending_reg <= 1'b0;
    end else begin
      cmd_valid_reg <= 1'b0;
      rd_req_reg <= 1'b0;
      case (state_reg)
        flash_op_pkg::H_IDLE: begin
          if (wr_cmd && !host_busy) begin
            cmd_valid_reg <= 1'b1;
            cmd_code_reg <= new_cmd;
            cmd_sector_reg <= pwdata[11:8];
            status_armed_reg <= (new_cmd == flash_op_pkg::CMD_STATUS_READ);
            if (new_cmd == flash_op_pkg::CMD_ERASE_SUSPEND ||
                new_cmd == flash_op_pkg::CMD_PROG_SUSPEND) begin
              suspend_pending_reg <= 1'b1;
            end
          end else if (wr_read && !host_busy) begin
            rd_req_reg <= 1'b1;
            rd_len_reg <= pwdata[3:0];
            status_burst_reg <= status_armed_reg;
            status_armed_reg <= 1'b0;
            first_seen_reg <= 1'b0;
            state_reg <= flash_op_pkg::H_READ;
          end
        end
        flash_op_pkg::H_READ: begin
          if (link.burst_busy || rd_req_reg) begin
            if (link.rd_strobe != link.rd_strobe) begin
              first_seen_reg <= 1'b1;
            end
          end else if (link.rd_done || !link.burst_busy) begin
            state_reg <= flash_op_pkg::H_IDLE;
          end
          if (!first_seen_reg && link.rd_done && status_burst_reg && status_ready) begin
            suspend_pending_reg <= 1'b0;
          end
        end
        default: begin
          state_reg <= flash_op_pkg::H_IDLE;
        end
      endcase
    end
  end

  // The device updates data in the same cycle as each burst step; the word kept
  // is the last one, present once burst_busy has dropped, at rd_done.
  logic strobe_seen_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strobe_seen_reg <= 1'b0;
      word_reg <= 16'h0000;
      valid_status_reg <= 16'h0080;
      status_valid_reg <= 1'b0;
    end else if (state_reg == flash_op_pkg::H_READ && rd_req_reg) begin
      strobe_seen_reg <= 1'b0;
    end else if (state_reg == flash_op_pkg::H_READ && !strobe_seen_reg &&
                 !link.burst_busy && !rd_req_reg) begin
      strobe_seen_reg <= 1'b1;
      word_reg <= status_burst_reg ? masked_word : link.rd_data;
      if (status_burst_reg) begin
        status_valid_reg <= status_ready;
        if (status_ready) begin
          valid_status_reg <= masked_word;
        end
      end
    end
  end
endmodule

// ### src/op_link_if.sv
`timescale 1ns/1ps
interface op_link_if;
  logic cmd_valid;
  flash_op_pkg::cmd_t cmd_code;
  logic [3:0] cmd_sector;
  logic rd_req;
  logic [3:0] rd_len;
  logic rd_strobe;
  logic [15:0] rd_data;
  logic rd_done;
  logic burst_busy;

  modport dev (
    input cmd_valid, cmd_code, cmd_sector, rd_req, rd_len,
    output rd_strobe, rd_data, rd_done, burst_busy
  );
  modport host (
    output cmd_valid, cmd_code, cmd_sector, rd_req, rd_len,
    input rd_strobe, rd_data, rd_done, burst_busy
  );
endinterface

// ### verif/flash_op_link_properties.sv
`timescale 1ns/1ps
module flash_op_link_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cmd_valid,
  input wire flash_op_pkg::cmd_t cmd_code,
  input wire logic [3:0] cmd_sector,
  input wire logic rd_req,
  input wire logic [3:0] rd_len,
  input wire logic rd_strobe,
  input wire logic [15:0] rd_data,
  input wire logic rd_done,
  input wire logic burst_busy
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_done_toggles; rd_done |-> $changed(rd_strobe); endproperty
  a_done_toggles: assert property (p_done_toggles)
    else $error("last word came without a strobe toggle");
  property p_strobe_in_burst; $changed(rd_strobe) |-> $past(burst_busy); endproperty
  a_strobe_in_burst: assert property (p_strobe_in_burst)
    else $error("strobe toggled outside a burst");
  property p_done_idle; rd_done |-> !burst_busy; endproperty
  a_done_idle: assert property (p_done_idle)
    else $error("burst still busy with last word");
  property p_done_pulse; rd_done |=> !rd_done; endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("done held longer than one cycle");
  property p_req_pulse; rd_req |=> !rd_req; endproperty
  a_req_pulse: assert property (p_req_pulse)
    else $error("read request held longer than one cycle");
  property p_busy_after_req;
    rd_req && !burst_busy && rd_len == 4'h1 |=> burst_busy ##[1:2] rd_done;
  endproperty
  a_busy_after_req: assert property (p_busy_after_req)
    else $error("single word read did not run as a one word burst");
  property p_burst_ends; $rose(burst_busy) |-> ##[0:16] rd_done; endproperty
  a_burst_ends: assert property (p_burst_ends)
    else $error("burst did not finish");
  property p_rdata_hold; !$changed(rd_strobe) |-> $stable(rd_data); endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved without a strobe toggle");
  c_done: cover property (rd_done);
  c_susp: cover property (cmd_valid && cmd_code == flash_op_pkg::CMD_ERASE_SUSPEND);
  c_erase3: cover property (cmd_valid && cmd_code == flash_op_pkg::CMD_ERASE && cmd_sector == 4'h3);
endmodule

// ### verif/flash_op_status_and_error_logic_tb_top.sv
`timescale 1ns/1ps
`include "flash_op_defines.svh"
module flash_op_status_and_error_logic_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic target_protected, op_fail, wbuf_error, device_ready_flag;
  logic [15:0] array_word, status_word, lfsr;
  logic [3:0] sec;
  logic [16:0] exp_q[$];
  int n_mismatch, checks_done, n;
  flash_op_pkg::cmd_t fcode[4] = '{flash_op_pkg::CMD_ERASE, flash_op_pkg::CMD_BLANK_CHECK,
    flash_op_pkg::CMD_PROGRAM, flash_op_pkg::CMD_PW_UNLOCK};
  logic [8:0] fexp[4] = '{9'h0A0, 9'h0A0, 9'h090, 9'h090};
  op_link_if op_link_if_inst();
  flash_op_status_dev flash_op_status_dev_inst(.pclk(pclk), .presetn(presetn),
    .link(op_link_if_inst), .target_protected(target_protected), .op_fail(op_fail),
    .wbuf_error(wbuf_error), .array_word(array_word), .status_word(status_word),
    .device_ready_flag(device_ready_flag));
  flash_op_status_host flash_op_status_host_inst(.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(op_link_if_inst));
  flash_op_link_properties flash_op_link_properties_inst(.pclk(pclk), .presetn(presetn),
    .cmd_valid(op_link_if_inst.cmd_valid), .cmd_code(op_link_if_inst.cmd_code),
    .cmd_sector(op_link_if_inst.cmd_sector), .rd_req(op_link_if_inst.rd_req),
    .rd_len(op_link_if_inst.rd_len), .rd_strobe(op_link_if_inst.rd_strobe),
    .rd_data(op_link_if_inst.rd_data), .rd_done(op_link_if_inst.rd_done),
    .burst_busy(op_link_if_inst.burst_busy));
  always #5 pclk = ~pclk;
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input logic ok, input string m);
    checks_done++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("MISMATCH at %0t: %s", $time, m);
    end
  endtask
  task automatic summarize;
    $display("mismatches %0d, checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] r);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 100);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // The host drops orders written while its link is busy, so every order waits here.
  task automatic wait_host;
    logic [31:0] r;
    int k;
    k = 0;
    do begin
      apb(1'b0, `HOST_STAT_OFS, 32'h0, r);
      k++;
    end while (r[0] !== 1'b0 && k < 50);
  endtask
  task automatic cmd(input flash_op_pkg::cmd_t c, input logic [3:0] s);
    logic [31:0] r;
    apb(1'b1, `HOST_CMD_OFS, {20'h0, s, 4'h0, c}, r);
    wait_host();
  endtask
  task automatic rd(input logic [16:0] e);
    logic [31:0] r;
    exp_q.push_back(e);
    apb(1'b1, `HOST_READ_OFS, 32'h1, r);
    wait_host();
    apb(1'b0, `HOST_WORD_OFS, 32'h0, r);
  endtask
  task automatic stat(input logic [8:0] e);
    cmd(flash_op_pkg::CMD_STATUS_READ, sec);
    rd({8'h80, e});
  endtask
  task automatic wait_ready;
    n = 0;
    repeat (2) @(posedge pclk);
    while (device_ready_flag !== 1'b1 && n < 12000) begin
      @(posedge pclk);
      n++;
    end
  endtask
  // Status words are compared on bits 8:0 only; the host has already cleared bits 15:9 to zero.
  always @(posedge pclk) begin
    if ((psel & penable & pready & ~pwrite) === 1'b1 && paddr == `HOST_WORD_OFS) begin
      if (exp_q.size() == 0) chk(1'b0, "unexpected word read");
      else if (exp_q[0][16]) chk(prdata[8:0] === exp_q.pop_front()[8:0], "status word");
      else chk(prdata[15:0] === exp_q.pop_front()[15:0], "array word");
    end
  end
  initial begin
    repeat (40000) @(posedge pclk);
    n_mismatch++;
    summarize();
  end
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {target_protected, op_fail, wbuf_error} = 3'h0;
    lfsr = 16'h0063;
    array_word = lfsr;
    sec = lfsr[3:0];
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    chk(status_word[8:0] === 9'h080 && device_ready_flag === 1'b1, "reset word");
    cmd(flash_op_pkg::CMD_PROGRAM, sec);
    chk(device_ready_flag === 1'b0 && status_word[7] === 1'b0, "busy flag");
    wait_ready();
    stat(9'h080);
    lfsr = lfsr_next(lfsr);
    array_word <= lfsr;
    rd({1'b0, lfsr});
    for (int i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      sec = lfsr[3:0];
      op_fail <= 1'b1;
      cmd(fcode[i], sec);
      wait_ready();
      op_fail <= 1'b0;
      stat(fexp[i]);
      cmd(flash_op_pkg::CMD_PROGRAM, sec);
      chk(device_ready_flag === 1'b1, "ignored order ran");
      stat(fexp[i]);
      cmd(i[0] ? flash_op_pkg::CMD_SW_RESET : flash_op_pkg::CMD_CLEAR_STATUS, sec);
      stat(9'h080);
    end
    for (int j = 0; j < 2; j++) begin
      target_protected <= 1'b1;
      cmd(j ? flash_op_pkg::CMD_ERASE : flash_op_pkg::CMD_PROGRAM, sec);
      wait_ready();
      target_protected <= 1'b0;
      chk(n >= 1950 && n <= 10000, "protection busy span");
      stat(j ? 9'h0A2 : 9'h092);
      cmd(j ? flash_op_pkg::CMD_ERASE : flash_op_pkg::CMD_PROGRAM, sec);
      wait_ready();
      stat(9'h080);
    end
    for (int k = 0; k < 2; k++) begin
      wbuf_error <= 1'b1;
      cmd(flash_op_pkg::CMD_BUF_WRITE, sec);
      wait_ready();
      wbuf_error <= 1'b0;
      stat(9'h098);
      cmd(flash_op_pkg::CMD_ERASE, sec);
      stat(9'h098);
      cmd(k ? flash_op_pkg::CMD_CLEAR_STATUS : flash_op_pkg::CMD_WB_ABORT_RESET, sec);
      stat(9'h080);
    end
    cmd(flash_op_pkg::CMD_ERASE, 4'h3);
    cmd(flash_op_pkg::CMD_ERASE_SUSPEND, 4'h3);
    wait_ready();
    stat(9'h0C0);
    cmd(flash_op_pkg::CMD_PROGRAM, 4'h3);
    wait_ready();
    stat(9'h0D0);
    cmd(flash_op_pkg::CMD_CLEAR_STATUS, 4'h3);
    stat(9'h0C0);
    cmd(flash_op_pkg::CMD_ERASE_RESUME, 4'h3);
    wait_ready();
    stat(9'h080);
    cmd(flash_op_pkg::CMD_ERASE_QUERY, 4'h3);
    wait_ready();
    stat(9'h081);
    cmd(flash_op_pkg::CMD_PROGRAM, 4'h5);
    cmd(flash_op_pkg::CMD_PROG_SUSPEND, 4'h5);
    wait_ready();
    stat(9'h085);
    cmd(flash_op_pkg::CMD_PROG_RESUME, 4'h5);
    wait_ready();
    stat(9'h081);
    summarize();
  end
endmodule
